// ### pfid_pkg.sv
// pfid_pkg.sv: register offsets, feature layout and build-time feature choices
package pfid_pkg;

	// ------------------------------------------------------------
	// architecture versions
	// ------------------------------------------------------------
	localparam logic [3:0] PFID_MAJOR_REV = 4'h1;
	localparam logic [3:0] PFID_MINOR_V10 = 4'h0;
	localparam logic [3:0] PFID_MINOR_V11 = 4'h1;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] PFID_OFF_FEAT_LO = 12'h000;
	localparam logic [11:0] PFID_OFF_FEAT_HI = 12'h004;
	localparam logic [11:0] PFID_OFF_VER = 12'h008;
	localparam logic [11:0] PFID_OFF_CAP = 12'h00C;
	localparam logic [11:0] PFID_OFF_BW_PART = 12'h010;
	localparam logic [11:0] PFID_OFF_BW_MON = 12'h014;
	localparam logic [11:0] PFID_OFF_STORE_MON = 12'h018;
	localparam logic [11:0] PFID_OFF_IMPL = 12'h01C;
	localparam logic [11:0] PFID_OFF_ERR_LO = 12'h020;
	localparam logic [11:0] PFID_OFF_ERR_HI = 12'h024;
	localparam logic [11:0] PFID_OFF_ERR_CTL = 12'h028;
	localparam logic [11:0] PFID_OFF_INST_SEL = 12'h02C;
	localparam logic [11:0] PFID_OFF_BW_CNT_LO = 12'h030;
	localparam logic [11:0] PFID_OFF_BW_CNT_HI = 12'h034;
	localparam logic [11:0] PFID_OFF_BW_CNT_CTL = 12'h038;

	// ------------------------------------------------------------
	// feature register bit positions (64-bit register)
	// ------------------------------------------------------------
	localparam int PFID_B_CAP_PART = 0;
	localparam int PFID_B_BW_PART = 1;
	localparam int PFID_B_MONITOR = 2;
	localparam int PFID_B_IMPL_ID = 3;
	localparam int PFID_B_EXT = 32;
	localparam int PFID_B_NO_IMPL_PART = 33;
	localparam int PFID_B_NO_IMPL_MON = 34;
	localparam int PFID_B_INST_SEL = 35;
	localparam int PFID_B_ERR_STATUS = 36;
	localparam int PFID_B_EXT_ERR = 37;

	// capacity option bits
	localparam int PFID_B_MIN_CAP = 0;
	localparam int PFID_B_NO_MAX_CAP = 1;
	localparam int PFID_B_MAX_ASSOC = 2;
	localparam int PFID_B_SOFT_LIM = 3;

	// bandwidth partitioning option bits
	localparam int PFID_B_BW_MIN = 0;
	localparam int PFID_B_BW_MAX = 1;
	localparam int PFID_B_BW_MAX_LIM = 2;
	localparam int PFID_B_BW_PBM = 3;
	localparam int PFID_B_BW_PROP = 4;
	localparam int PFID_B_BW_WINDWR = 5;

	// bandwidth monitor option bits
	localparam int PFID_B_BW_LONG = 0;
	localparam int PFID_B_BW_LONG63 = 1;

	// storage monitor option bits
	localparam int PFID_B_EXCL = 0;
	localparam int PFID_B_OFL_LINK = 1;
	localparam int PFID_B_OFL_SR = 2;
	localparam int PFID_B_OFL_CAPT = 3;

	// implementation-defined discovery fields
	localparam int PFID_B_IMPL_PART = 0;
	localparam int PFID_B_IMPL_MON = 1;

	// ------------------------------------------------------------
	// counter widths and reset values
	// ------------------------------------------------------------
	localparam int PFID_CNT_SHORT_W = 31;
	localparam int PFID_CNT_44_W = 44;
	localparam int PFID_CNT_63_W = 63;
	localparam int PFID_INST_W = 4;
	localparam logic [31:0] PFID_RST_WORD = 32'h0000_0000;

	// ------------------------------------------------------------
	// build-time feature choices
	// ------------------------------------------------------------
	localparam logic [3:0] PFID_CFG_MINOR = PFID_MINOR_V11;
	localparam logic PFID_CFG_CAP_PART = 1'b1;
	localparam logic PFID_CFG_BW_PART = 1'b1;
	localparam logic PFID_CFG_MONITOR = 1'b1;
	localparam logic PFID_CFG_IMPL_ID = 1'b1;
	localparam logic PFID_CFG_IMPL_PART = 1'b0;
	localparam logic PFID_CFG_IMPL_MON = 1'b1;
	localparam logic PFID_CFG_INST_SEL = 1'b1;
	localparam logic PFID_CFG_ERR_STATUS = 1'b1;
	localparam logic PFID_CFG_EXT_ERR = 1'b1;
	localparam logic [3:0] PFID_CFG_CAP_OPTS = 4'hB;
	localparam logic [5:0] PFID_CFG_BW_OPTS = 6'h2B;
	localparam logic PFID_CFG_BW_LONG = 1'b1;
	localparam logic PFID_CFG_BW_LONG63 = 1'b1;
	localparam logic [3:0] PFID_CFG_STORE_OPTS = 4'h5;

	typedef enum logic [1:0] {
		PFID_IDLE = 2'b00,
		PFID_ACCESS = 2'b01
	} pfid_state_type;

endpackage : pfid_pkg

// ### pfid_regbus_if.sv
// pfid_regbus_if.sv: decoded register access between bus slave and register bank
`timescale 1ns/1ps
interface pfid_regbus_if;
	logic wr_en;
	logic rd_en;
	logic [11:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic hit;

	modport slave (output wr_en, rd_en, addr, wdata, input rdata, hit);
	modport bank (input wr_en, rd_en, addr, wdata, output rdata, hit);
endinterface : pfid_regbus_if

// ### pfid_apb_slave.sv
// pfid_apb_slave.sv: apb slave that turns transfers into register strobes
`timescale 1ns/1ps
module pfid_apb_slave
	import pfid_pkg::*;
(
	input wire logic clk_i, // core clock
	input wire logic rst_n_i, // synchronised reset
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb enable
	input wire logic pwrite_i, // apb direction
	input wire logic [11:0] paddr_i, // apb address
	input wire logic [31:0] pwdata_i, // apb write data
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error
	pfid_regbus_if.slave rb // register strobes
);
	pfid_state_type state_r;
	logic [31:0] prdata_r;
	logic pslverr_r;

	// no wait state: setup, then access answered from registered data
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= PFID_IDLE;
		end else if (psel_i && !penable_i) begin
			state_r <= PFID_ACCESS;
		end else begin
			state_r <= PFID_IDLE;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_r <= PFID_RST_WORD;
			pslverr_r <= 1'b0;
		end else if (psel_i && !penable_i) begin
			prdata_r <= rb.rd_en ? rb.rdata : PFID_RST_WORD;
			pslverr_r <= !rb.hit;
		end
	end

	assign rb.addr = paddr_i;
	assign rb.wdata = pwdata_i;
	assign rb.rd_en = psel_i && !penable_i && !pwrite_i;
	// write lands at the completing edge only
	assign rb.wr_en = psel_i && penable_i && pwrite_i && state_r == PFID_ACCESS && rb.hit;
	assign pready_o = psel_i && penable_i && state_r == PFID_ACCESS;
	assign prdata_o = prdata_r;
	assign pslverr_o = pready_o && pslverr_r;

endmodule : pfid_apb_slave

// ### pfid_top.sv
// pfid_top.sv: feature identification registers of a partitioning memory component
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
module pfid_top
	import pfid_pkg::*;
(
	input wire logic REF_CLK_I, // 250 MHz clock
	input wire logic RSTN_I, // async reset, active low
	input wire logic PSEL_I, // apb select
	input wire logic PENABLE_I, // apb enable
	input wire logic PWRITE_I, // apb direction
	input wire logic [11:0] PADDR_I, // apb byte address
	input wire logic [31:0] PWDATA_I, // apb write data
	output logic [31:0] PRDATA_O, // apb read data
	output logic PREADY_O, // apb ready
	output logic PSLVERR_O, // apb error on unmapped address
	input wire logic ERR_EVENT_I, // one-cycle error report from component logic
	input wire logic [3:0] ERR_CODE_I, // error code with the report
	input wire logic BW_BYTES_I, // one-cycle pulse per counted bandwidth unit
	output logic [PFID_INST_W-1:0] INST_SEL_O, // selected resource instance
	output logic ERR_IRQ_EN_O // error report enable from control register
);
	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// ------------------------------------------------------------
	// fixed feature flags
	// ------------------------------------------------------------
	logic is_v11;
	logic ext_flag;
	logic impl_present_flag;
	logic inst_sel_present_flag;
	logic err_present_flag;
	logic ext_err_flag;
	logic [63:0] feat_id;
	logic [3:0] cap_opts;
	logic [5:0] bw_part_opts;
	logic [1:0] bw_mon_opts;
	logic [3:0] store_opts;
	logic [1:0] impl_fields;

	assign is_v11 = PFID_CFG_MINOR == PFID_MINOR_V11;
	assign ext_flag = is_v11;
	assign impl_present_flag = PFID_CFG_IMPL_ID;
	assign inst_sel_present_flag = ext_flag && PFID_CFG_INST_SEL;
	assign err_present_flag = ext_flag && PFID_CFG_ERR_STATUS;
	assign ext_err_flag = ext_flag && (PFID_CFG_EXT_ERR
		|| (err_present_flag && inst_sel_present_flag));

	assign impl_fields = (ext_flag && impl_present_flag)
		? {PFID_CFG_IMPL_MON, PFID_CFG_IMPL_PART} : 2'b00;

	// constant flags, prohibited ones forced low
	always_comb begin
		feat_id = 64'h0;
		feat_id[PFID_B_CAP_PART] = PFID_CFG_CAP_PART;
		feat_id[PFID_B_BW_PART] = PFID_CFG_BW_PART;
		feat_id[PFID_B_MONITOR] = PFID_CFG_MONITOR;
		feat_id[PFID_B_IMPL_ID] = impl_present_flag;
		// upper word only in newer version
		if (ext_flag) begin
			feat_id[PFID_B_EXT] = 1'b1;
			feat_id[PFID_B_NO_IMPL_PART] = !impl_fields[PFID_B_IMPL_PART];
			feat_id[PFID_B_NO_IMPL_MON] = !impl_fields[PFID_B_IMPL_MON];
			feat_id[PFID_B_INST_SEL] = inst_sel_present_flag;
			feat_id[PFID_B_ERR_STATUS] = err_present_flag;
			feat_id[PFID_B_EXT_ERR] = ext_err_flag;
		end
	end

	// ------------------------------------------------------------
	// feature option words
	// ------------------------------------------------------------
	// newer capacity options hidden in base version
	always_comb begin
		cap_opts = 4'h0;
		if (is_v11 && PFID_CFG_CAP_PART) begin
			cap_opts[PFID_B_MIN_CAP] = PFID_CFG_CAP_OPTS[PFID_B_MIN_CAP];
			cap_opts[PFID_B_NO_MAX_CAP] = PFID_CFG_CAP_OPTS[PFID_B_NO_MAX_CAP];
			cap_opts[PFID_B_MAX_ASSOC] = PFID_CFG_CAP_OPTS[PFID_B_MAX_ASSOC];
			cap_opts[PFID_B_SOFT_LIM] = PFID_CFG_CAP_OPTS[PFID_B_SOFT_LIM];
		end
	end

	// own flag per bandwidth option
	// every version may offer these, so only the partitioning flag gates them
	always_comb begin
		bw_part_opts = 6'h00;
		if (PFID_CFG_BW_PART) begin
			bw_part_opts[PFID_B_BW_MIN] = PFID_CFG_BW_OPTS[PFID_B_BW_MIN];
			bw_part_opts[PFID_B_BW_MAX] = PFID_CFG_BW_OPTS[PFID_B_BW_MAX];
			bw_part_opts[PFID_B_BW_MAX_LIM] = PFID_CFG_BW_OPTS[PFID_B_BW_MAX_LIM];
			bw_part_opts[PFID_B_BW_PBM] = PFID_CFG_BW_OPTS[PFID_B_BW_PBM];
			bw_part_opts[PFID_B_BW_PROP] = PFID_CFG_BW_OPTS[PFID_B_BW_PROP];
			bw_part_opts[PFID_B_BW_WINDWR] = PFID_CFG_BW_OPTS[PFID_B_BW_WINDWR];
		end
	end

	// long flag matches built counters; 63-bit needs the long option
	always_comb begin
		bw_mon_opts = 2'b00;
		if (PFID_CFG_MONITOR) begin
			bw_mon_opts[PFID_B_BW_LONG] = PFID_CFG_BW_LONG;
			bw_mon_opts[PFID_B_BW_LONG63] = PFID_CFG_BW_LONG && PFID_CFG_BW_LONG63;
		end
	end

	// storage options hidden in base version
	always_comb begin
		store_opts = 4'h0;
		if (is_v11 && PFID_CFG_MONITOR) begin
			store_opts[PFID_B_EXCL] = PFID_CFG_STORE_OPTS[PFID_B_EXCL];
			store_opts[PFID_B_OFL_LINK] = PFID_CFG_STORE_OPTS[PFID_B_OFL_LINK];
			store_opts[PFID_B_OFL_SR] = PFID_CFG_STORE_OPTS[PFID_B_OFL_SR];
			store_opts[PFID_B_OFL_CAPT] = PFID_CFG_STORE_OPTS[PFID_B_OFL_CAPT];
		end
	end

	// ------------------------------------------------------------
	// instance selection
	// ------------------------------------------------------------
	logic [PFID_INST_W-1:0] inst_sel_r;
	// one control word for every selector value, so no access falls off the end
	logic [31:0] bw_cnt_ctl_r [2**PFID_INST_W];

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	pfid_regbus_if rb();

	pfid_apb_slave u_apb (
		.clk_i(REF_CLK_I),
		.rst_n_i(rst_n_r),
		.psel_i(PSEL_I),
		.penable_i(PENABLE_I),
		.pwrite_i(PWRITE_I),
		.paddr_i(PADDR_I),
		.pwdata_i(PWDATA_I),
		.prdata_o(PRDATA_O),
		.pready_o(PREADY_O),
		.pslverr_o(PSLVERR_O),
		.rb(rb)
	);

	always_ff @(posedge REF_CLK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			inst_sel_r <= '0;
		end else if (rb.wr_en && rb.addr == PFID_OFF_INST_SEL && inst_sel_present_flag) begin
			inst_sel_r <= rb.wdata[PFID_INST_W-1:0];
		end
	end

	// per-instance bandwidth counter control, one word each
	genvar gi;
	generate
		for (gi = 0; gi < 2**PFID_INST_W; gi++) begin : g_inst
			always_ff @(posedge REF_CLK_I or negedge rst_n_r) begin
				if (!rst_n_r) begin
					bw_cnt_ctl_r[gi] <= PFID_RST_WORD;
				end else if (rb.wr_en && rb.addr == PFID_OFF_BW_CNT_CTL
					&& inst_sel_r == PFID_INST_W'(gi)) begin
					bw_cnt_ctl_r[gi] <= rb.wdata;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// error status and control
	// ------------------------------------------------------------
	logic [3:0] err_code_r;
	logic err_valid_r;
	logic [PFID_INST_W-1:0] err_inst_r;
	logic [63:0] err_status;
	logic err_set;
	logic [31:0] err_ctl_r;
	logic err_clr;

	assign err_clr = rb.wr_en && rb.addr == PFID_OFF_ERR_LO && err_present_flag;

	always_ff @(posedge REF_CLK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			err_ctl_r <= PFID_RST_WORD;
		end else if (rb.wr_en && rb.addr == PFID_OFF_ERR_CTL && err_present_flag) begin
			err_ctl_r <= rb.wdata;
		end
	end

	assign err_set = ERR_EVENT_I && err_present_flag;

	// a new error wins over a clear in the same cycle
	always_ff @(posedge REF_CLK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			err_code_r <= 4'h0;
			err_valid_r <= 1'b0;
		end else if (err_set) begin
			err_code_r <= ERR_CODE_I;
			err_valid_r <= 1'b1;
		end else if (err_clr) begin
			err_code_r <= 4'h0;
			err_valid_r <= 1'b0;
		end
	end

	// 64-bit status holds instance field in the upper word
	// field only moves when the extended status exists
	always_ff @(posedge REF_CLK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			err_inst_r <= '0;
		end else if (err_set && ext_err_flag) begin
			err_inst_r <= inst_sel_r;
		end else if (err_clr) begin
			err_inst_r <= '0;
		end
	end

	// status word as software sees it
	always_comb begin
		err_status = 64'h0;
		err_status[3:0] = err_code_r;
		err_status[31] = err_valid_r;
		err_status[32 +: PFID_INST_W] = err_inst_r;
	end

	// ------------------------------------------------------------
	// bandwidth usage counter
	// ------------------------------------------------------------
	logic [PFID_CNT_63_W-1:0] bw_cnt_r;
	logic [PFID_CNT_63_W-1:0] bw_cnt_nxt;
	logic [PFID_CNT_63_W-1:0] cnt_mask;
	logic long63_sel;

	// 63-bit mode only where built, chosen by the selected instance's control word
	assign long63_sel = bw_mon_opts[PFID_B_BW_LONG63] && bw_cnt_ctl_r[inst_sel_r][0];

	// 44 or 63 bits by control, short width otherwise
	// wrap by masking so the count never carries into bits software cannot see
	always_comb begin
		cnt_mask = {PFID_CNT_63_W{1'b1}} >> (PFID_CNT_63_W - PFID_CNT_SHORT_W);
		if (bw_mon_opts[PFID_B_BW_LONG]) begin
			if (long63_sel) begin
				cnt_mask = {PFID_CNT_63_W{1'b1}};
			end else begin
				cnt_mask = {PFID_CNT_63_W{1'b1}} >> (PFID_CNT_63_W - PFID_CNT_44_W);
			end
		end
		bw_cnt_nxt = (bw_cnt_r + PFID_CNT_63_W'(1)) & cnt_mask;
	end

	always_ff @(posedge REF_CLK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			bw_cnt_r <= '0;
		end else if (rb.wr_en && rb.addr == PFID_OFF_BW_CNT_LO) begin
			bw_cnt_r <= '0;
		end else if (BW_BYTES_I) begin
			bw_cnt_r <= bw_cnt_nxt;
		end
	end

	// ------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------
	// unmapped offsets answer with an error and never take a write
	always_comb begin
		rb.hit = 1'b0;
		case (rb.addr)
			PFID_OFF_FEAT_LO, PFID_OFF_FEAT_HI, PFID_OFF_VER, PFID_OFF_CAP: rb.hit = 1'b1;
			PFID_OFF_BW_PART, PFID_OFF_BW_MON, PFID_OFF_STORE_MON, PFID_OFF_IMPL: rb.hit = 1'b1;
			PFID_OFF_ERR_LO, PFID_OFF_ERR_HI, PFID_OFF_ERR_CTL, PFID_OFF_INST_SEL: rb.hit = 1'b1;
			PFID_OFF_BW_CNT_LO, PFID_OFF_BW_CNT_HI, PFID_OFF_BW_CNT_CTL: rb.hit = 1'b1;
			default: rb.hit = 1'b0;
		endcase
	end

	always_comb begin
		rb.rdata = PFID_RST_WORD;
		case (rb.addr)
			PFID_OFF_FEAT_LO: rb.rdata = feat_id[31:0];
			PFID_OFF_FEAT_HI: rb.rdata = feat_id[63:32];
			PFID_OFF_VER: rb.rdata = {24'h0, PFID_MAJOR_REV, PFID_CFG_MINOR};
			PFID_OFF_CAP: rb.rdata = {28'h0, cap_opts};
			PFID_OFF_BW_PART: rb.rdata = {26'h0, bw_part_opts};
			PFID_OFF_BW_MON: rb.rdata = {30'h0, bw_mon_opts};
			PFID_OFF_STORE_MON: rb.rdata = {28'h0, store_opts};
			PFID_OFF_IMPL: rb.rdata = {30'h0, impl_fields};
			PFID_OFF_ERR_LO: rb.rdata = err_status[31:0];
			PFID_OFF_ERR_HI: rb.rdata = ext_err_flag ? err_status[63:32] : PFID_RST_WORD;
			PFID_OFF_ERR_CTL: rb.rdata = err_ctl_r;
			PFID_OFF_INST_SEL: rb.rdata = {{(32-PFID_INST_W){1'b0}}, inst_sel_r};
			PFID_OFF_BW_CNT_LO: rb.rdata = bw_cnt_r[31:0];
			PFID_OFF_BW_CNT_HI: rb.rdata = {1'b0, bw_cnt_r[62:32]};
			PFID_OFF_BW_CNT_CTL: rb.rdata = bw_cnt_ctl_r[inst_sel_r];
			default: rb.rdata = PFID_RST_WORD;
		endcase
	end

	assign INST_SEL_O = inst_sel_r;
	assign ERR_IRQ_EN_O = err_ctl_r[0];

endmodule : pfid_top

// ### pfid_chk.sv
// pfid_chk.sv: port-level assertions for the feature identification registers
`timescale 1ns/1ps
module pfid_chk
	import pfid_pkg::*;
(
	input wire logic REF_CLK_I, // clock
	input wire logic RSTN_I, // async reset, active low
	input wire logic PSEL_I, // apb select
	input wire logic PENABLE_I, // apb enable
	input wire logic PWRITE_I, // apb direction
	input wire logic [11:0] PADDR_I, // apb address
	input wire logic [31:0] PWDATA_I, // apb write data
	input wire logic [31:0] PRDATA_O, // apb read data
	input wire logic PREADY_O, // apb ready
	input wire logic PSLVERR_O, // apb error
	input wire logic ERR_EVENT_I, // error report
	input wire logic [3:0] ERR_CODE_I, // error code
	input wire logic BW_BYTES_I, // bandwidth unit
	input wire logic [PFID_INST_W-1:0] INST_SEL_O, // selected instance
	input wire logic ERR_IRQ_EN_O // error report enable
);
	// ------------------------------------------------------------
	// completed transfers
	// ------------------------------------------------------------
	logic rd_acc;
	logic wr_acc;
	assign rd_acc = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I;
	assign wr_acc = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RSTN_I);

	feat_lo_a: assert property (rd_acc && PADDR_I == 12'h000 |-> PRDATA_O == 32'h0000_000F)
		else $error("feature low word wrong");
	feat_hi_a: assert property (rd_acc && PADDR_I == 12'h004 |-> PRDATA_O == 32'h0000_003B)
		else $error("feature high word wrong");
	cap_opts_a: assert property (rd_acc && PADDR_I == 12'h00C |-> PRDATA_O == 32'h0000_000B)
		else $error("capacity options wrong");
	bw_opts_a: assert property (rd_acc && PADDR_I == 12'h010 |-> PRDATA_O == 32'h0000_002B)
		else $error("bandwidth options wrong");
	bw_long_a: assert property (rd_acc && PADDR_I == 12'h014 |-> PRDATA_O == 32'h0000_0003)
		else $error("long counter flags wrong");
	store_opts_a: assert property (rd_acc && PADDR_I == 12'h018 |-> PRDATA_O == 32'h0000_0005)
		else $error("storage monitor options wrong");
	impl_fields_a: assert property (rd_acc && PADDR_I == 12'h01C |-> PRDATA_O == 32'h0000_0002)
		else $error("discovery fields wrong");
	inst_write_a: assert property (wr_acc && PADDR_I == 12'h02C |=> ({28'h0, INST_SEL_O} == ($past(PWDATA_I) & 32'h0000_000F)))
		else $error("instance select not taken");
	err_en_write_a: assert property (wr_acc && PADDR_I == 12'h028 |=> ERR_IRQ_EN_O == $past(PWDATA_I[0]))
		else $error("error enable not taken");
	ready_one_a: assert property (PSEL_I && !PENABLE_I ##1 PSEL_I && PENABLE_I |-> PREADY_O)
		else $error("ready not in first access cycle");
	unmapped_err_a: assert property (PSEL_I && PENABLE_I && PADDR_I > 12'h038 |-> PSLVERR_O && PREADY_O)
		else $error("unmapped access not refused");
endmodule : pfid_chk

bind pfid_top pfid_chk chk (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
	.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .ERR_EVENT_I(ERR_EVENT_I),
	.ERR_CODE_I(ERR_CODE_I), .BW_BYTES_I(BW_BYTES_I), .INST_SEL_O(INST_SEL_O),
	.ERR_IRQ_EN_O(ERR_IRQ_EN_O));

// ### tb_top.sv
// tb_top.sv: self-checking bench for the feature identification registers
`timescale 1ns/1ps
module tb_top
	import pfid_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic err_ev = 1'b0;
	logic [3:0] err_code = 4'h0;
	logic bw_pulse = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [PFID_INST_W-1:0] inst_sel;
	logic err_en;
	int n_fail = 0;
	int compares = 0;
	logic [11:0] id_addr [8];
	logic [31:0] id_exp [8];
	logic [31:0] q;
	logic e;

	pfid_top uut (.REF_CLK_I(clk), .RSTN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .ERR_EVENT_I(err_ev), .ERR_CODE_I(err_code),
		.BW_BYTES_I(bw_pulse), .INST_SEL_O(inst_sel), .ERR_IRQ_EN_O(err_en));

	always #2 clk = ~clk;

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic results();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one apb transfer; an idle cycle follows so the next setup never overlaps the release
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			$display("[FAIL] ready expected 1 seen timeout");
			results();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask : xfer

	task automatic pulse_bw();
		bw_pulse <= 1'b1;
		@(posedge clk);
		bw_pulse <= 1'b0;
		@(posedge clk);
	endtask : pulse_bw

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		id_addr = '{PFID_OFF_FEAT_LO, PFID_OFF_FEAT_HI, PFID_OFF_CAP, PFID_OFF_BW_PART,
			PFID_OFF_BW_MON, PFID_OFF_STORE_MON, PFID_OFF_IMPL, PFID_OFF_VER};
		id_exp[0] = {28'h0, PFID_CFG_IMPL_ID, PFID_CFG_MONITOR, PFID_CFG_BW_PART, PFID_CFG_CAP_PART};
		// newer version: extended flag forced, no-impl flags inverse of the discovery fields
		id_exp[1] = {26'h0, PFID_CFG_EXT_ERR, PFID_CFG_ERR_STATUS, PFID_CFG_INST_SEL,
			!PFID_CFG_IMPL_MON, !PFID_CFG_IMPL_PART, 1'b1};
		id_exp[2] = {28'h0, PFID_CFG_CAP_OPTS};
		id_exp[3] = {26'h0, PFID_CFG_BW_OPTS};
		id_exp[4] = {30'h0, PFID_CFG_BW_LONG63, PFID_CFG_BW_LONG};
		id_exp[5] = {28'h0, PFID_CFG_STORE_OPTS};
		id_exp[6] = {30'h0, PFID_CFG_IMPL_MON, PFID_CFG_IMPL_PART};
		id_exp[7] = {24'h0, PFID_MAJOR_REV, PFID_CFG_MINOR};
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// id words read back unchanged after an attempted overwrite
		foreach (id_addr[i]) begin
			xfer(1'b1, id_addr[i], 32'hFFFF_FFFF, q, e);
			xfer(1'b0, id_addr[i], 32'h0, q, e);
			check("id_word", q, id_exp[i]);
			check("id_err", {31'h0, e}, 32'h0);
		end
		xfer(1'b0, 12'h03C, 32'h0, q, e);
		check("unmapped_err", {31'h0, e}, 32'h1);
		xfer(1'b0, 12'hFFC, 32'h0, q, e);
		check("top_err", {31'h0, e}, 32'h1);
		// instance select, boundary value first
		xfer(1'b1, PFID_OFF_INST_SEL, 32'h0000_000F, q, e);
		check("inst_max", {28'h0, inst_sel}, 32'hF);
		xfer(1'b1, PFID_OFF_INST_SEL, 32'h0000_000A, q, e);
		xfer(1'b0, PFID_OFF_INST_SEL, 32'h0, q, e);
		check("inst_rd", q & 32'hF, 32'hA);
		// error status capture and clear
		xfer(1'b1, PFID_OFF_ERR_CTL, 32'h0000_0001, q, e);
		check("err_en", {31'h0, err_en}, 32'h1);
		err_ev <= 1'b1;
		err_code <= 4'hC;
		@(posedge clk);
		err_ev <= 1'b0;
		@(posedge clk);
		xfer(1'b0, PFID_OFF_ERR_LO, 32'h0, q, e);
		check("err_lo", q, 32'h8000_000C);
		xfer(1'b0, PFID_OFF_ERR_HI, 32'h0, q, e);
		check("err_inst", q, 32'h0000_000A);
		xfer(1'b1, PFID_OFF_ERR_LO, 32'h0, q, e);
		xfer(1'b0, PFID_OFF_ERR_LO, 32'h0, q, e);
		check("err_clr", q, 32'h0);
		// bandwidth counter: count, clear, long width select
		repeat (3) pulse_bw();
		xfer(1'b0, PFID_OFF_BW_CNT_LO, 32'h0, q, e);
		check("bw_cnt", q, 32'h3);
		xfer(1'b0, PFID_OFF_BW_CNT_HI, 32'h0, q, e);
		check("bw_hi", q, 32'h0);
		xfer(1'b1, PFID_OFF_BW_CNT_LO, 32'h0, q, e);
		xfer(1'b0, PFID_OFF_BW_CNT_LO, 32'h0, q, e);
		check("bw_clr", q, 32'h0);
		xfer(1'b1, PFID_OFF_BW_CNT_CTL, 32'h0000_0001, q, e);
		xfer(1'b0, PFID_OFF_BW_CNT_CTL, 32'h0, q, e);
		check("bw_ctl", q & 32'h1, 32'h1);
		results();
	end
endmodule : tb_top
